/* File: hw/aec_pkg.sv */
// Purpose: constants for the converter event and power control block
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: offsets are word aligned
package aec_pkg;
  // register byte offsets
  localparam logic [3:0] OFF_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] OFF_RESULT_HIGH = 4'h4;
  localparam logic [3:0] OFF_RESULT_LOW = 4'h8;
  localparam logic [3:0] OFF_MODE = 4'hc;
  // status_control_reg field positions
  localparam int BIT_DONE = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_CONT = 5;
  localparam int CH_LSB = 0;
  localparam int CH_W = 5;
  // mode register field positions
  localparam int BIT_ASYNC_CLK = 0;
  localparam int BIT_EXT_CONV = 1;
  // channel code that powers the converter down
  localparam logic [4:0] CH_OFF = 5'h1f;
  // reset values
  localparam logic [4:0] CH_RESET = 5'h1f;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  // conversion time, in ns, and derived cycle count at 125 MHz
  localparam int CONV_TIME_NS = 8000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam logic [9:0] CONV_LAST = 10'(CONV_CYCLES - 1);
  // converter control states
  typedef enum logic [1:0] {AEC_IDLE, AEC_CONV} aec_state_e;
endpackage

/* File: hw/aec_ctrl.sv */
// Purpose: event, mode and low-power control around a 10-bit converter
// Assumes: wishbone classic slave, one clock, sync active-high reset
// Notes: the analog core is outside; its result arrives on sar_data_i
//
// Notes on behaviour
// - irq with done flag when enabled
// - done flag sets every conversion end
// - wait mode keeps converting and interrupting
// - low power without all-ones channel
// - stop without async clock aborts
// - restart after stop needs control write
// - results hold through stop abort
// - async clock keeps converting in stop
// - ext mode in stop waits trigger
// - hardware trigger tied inactive
// - break clears allowed when enable set
// - break protects flags when enable clear
// - two-step clear held across break
// - control write or low read clears flag
// - control write restarts unless channel off or held for trigger
// - continuous repeats unless ext mode in stop, single does one
// - result read or control write drops irq
`timescale 1ns/1ns
module aec_ctrl (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // system state from the integration unit
  input wire logic wait_mode_i,
  input wire logic stop_mode_i,
  input wire logic break_state_i,
  input wire logic break_clear_enable_i,
  // analog core
  input wire logic [9:0] sar_data_i,
  output logic conv_active_o,
  output logic conv_power_o,
  // interrupt request
  output logic irq_o
);
  // synchronisers for outside levels
  logic [1:0] stop_s, brk_s, bce_s, wait_s;
  logic stop_q, brk_q, bce_q, wait_q;
  // register state
  logic conv_irq_enable, next_conv_irq_enable;
  logic continuous_conv_select, next_continuous_conv_select;
  logic [4:0] channel_select, next_channel_select;
  logic conv_done_flag, next_conv_done_flag;
  logic async_clock_enable, next_async_clock_enable;
  logic ext_convert_mode, next_ext_convert_mode;
  logic [9:0] result, next_result;
  logic high_read_pending, next_high_read_pending; // two-step arm
  logic [31:0] next_dat;
  logic next_ack, next_irq;
  // converter sequencer
  aec_pkg::aec_state_e state, next_state;
  logic [9:0] cnt, next_cnt;
  // decoded accesses
  logic acc, wr_sc, rd_lo, rd_hi, clr_ok, conv_end, hw_trig, ext_hold;

  // match an access to a register offset
  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    return a == o;
  endfunction

  // hardware trigger has no source here
  assign hw_trig = 1'b0;
  assign acc = cyc_i && stb_i && !ack_o;
  assign wr_sc = acc && we_i && sel_i[0]
    && hit(adr_i, aec_pkg::OFF_STATUS_CONTROL);
  assign rd_lo = acc && !we_i && hit(adr_i, aec_pkg::OFF_RESULT_LOW);
  assign rd_hi = acc && !we_i && hit(adr_i, aec_pkg::OFF_RESULT_HIGH);
  // software clears only outside break, or with break clears allowed
  assign clr_ok = !brk_q || bce_q;
  assign conv_end = (state == aec_pkg::AEC_CONV)
    && (cnt == aec_pkg::CONV_LAST);
  // async clock plus ext mode in stop: only the trigger may start
  assign ext_hold = stop_q && async_clock_enable && ext_convert_mode;

  // two-stage synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_s <= 2'h0;
      brk_s <= 2'h0;
      bce_s <= 2'h0;
      wait_s <= 2'h0;
    end else begin
      stop_s <= {stop_s[0], stop_mode_i};
      brk_s <= {brk_s[0], break_state_i};
      bce_s <= {bce_s[0], break_clear_enable_i};
      wait_s <= {wait_s[0], wait_mode_i};
    end
  end
  assign stop_q = stop_s[1];
  assign brk_q = brk_s[1];
  assign bce_q = bce_s[1];
  assign wait_q = wait_s[1];

  // register and flag next values
  always_comb begin
    next_conv_irq_enable = conv_irq_enable;
    next_continuous_conv_select = continuous_conv_select;
    next_channel_select = channel_select;
    next_async_clock_enable = async_clock_enable;
    next_ext_convert_mode = ext_convert_mode;
    next_conv_done_flag = conv_done_flag;
    next_high_read_pending = high_read_pending;
    next_result = result;
    // control write fields
    if (wr_sc) begin
      next_conv_irq_enable = dat_i[aec_pkg::BIT_IRQ_EN];
      next_continuous_conv_select = dat_i[aec_pkg::BIT_CONT];
      next_channel_select = dat_i[aec_pkg::CH_LSB +: aec_pkg::CH_W];
    end
    // mode register write
    if (acc && we_i && sel_i[0] && hit(adr_i, aec_pkg::OFF_MODE)) begin
      next_async_clock_enable = dat_i[aec_pkg::BIT_ASYNC_CLK];
      next_ext_convert_mode = dat_i[aec_pkg::BIT_EXT_CONV];
    end
    // first step of the two-step clear, held during protected break
    if (rd_hi && clr_ok) begin
      next_high_read_pending = 1'b1;
    end
    // software clears of the done flag
    if (clr_ok && (wr_sc || rd_lo)) begin
      next_conv_done_flag = 1'b0;
      next_high_read_pending = 1'b0;
    end
    // completion sets flag whatever the enable; set wins
    if (conv_end) begin
      next_conv_done_flag = 1'b1;
      next_result = sar_data_i;
    end
  end

  // converter sequencer next values
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      aec_pkg::AEC_IDLE: begin
        // control write starts unless channel off or held for a trigger
        if (wr_sc && !ext_hold && dat_i[aec_pkg::CH_LSB +: aec_pkg::CH_W]
            != aec_pkg::CH_OFF) begin
          next_state = aec_pkg::AEC_CONV;
          next_cnt = 10'h000;
        end else if (stop_q && async_clock_enable && ext_convert_mode
            && hw_trig && channel_select != aec_pkg::CH_OFF) begin
          next_state = aec_pkg::AEC_CONV;
          next_cnt = 10'h000;
        end
      end
      aec_pkg::AEC_CONV: begin
        next_cnt = cnt + 10'h001;
        if (stop_q && !async_clock_enable) begin
          next_state = aec_pkg::AEC_IDLE;
          next_cnt = 10'h000;
        end else if (wr_sc) begin
          // abort and restart, or power down on all ones or when held for a trigger
          next_cnt = 10'h000;
          if (ext_hold
              || dat_i[aec_pkg::CH_LSB +: aec_pkg::CH_W] == aec_pkg::CH_OFF)
            next_state = aec_pkg::AEC_IDLE;
        end else if (conv_end) begin
          next_cnt = 10'h000;
          // continuous repeats unless ext mode in stop; single powers down
          if (!continuous_conv_select || (stop_q && ext_convert_mode))
            next_state = aec_pkg::AEC_IDLE;
        end
        // wait mode and async stop just keep running
      end
      default: begin
        next_state = aec_pkg::AEC_IDLE;
        next_cnt = 10'h000;
      end
    endcase
  end

  // bus answer and interrupt next values
  always_comb begin
    next_ack = acc;
    next_dat = 32'h0000_0000;
    if (acc && !we_i) begin
      case (adr_i)
        aec_pkg::OFF_STATUS_CONTROL:
          next_dat = {24'h000000, conv_done_flag, conv_irq_enable,
            continuous_conv_select, channel_select};
        aec_pkg::OFF_RESULT_HIGH: next_dat = {30'h0, result[9:8]};
        aec_pkg::OFF_RESULT_LOW: next_dat = {24'h000000, result[7:0]};
        aec_pkg::OFF_MODE:
          next_dat = {30'h0, ext_convert_mode, async_clock_enable};
        default: next_dat = 32'h0000_0000;
      endcase
    end
    next_irq = irq_o;
    // drop on result read or control write
    if (clr_ok && (wr_sc || rd_lo || rd_hi))
      next_irq = 1'b0;
    // raise with the flag when enabled
    if (conv_end && conv_irq_enable)
      next_irq = 1'b1;
  end

  // register everything
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_irq_enable <= 1'b0;
      continuous_conv_select <= 1'b0;
      channel_select <= aec_pkg::CH_RESET;
      async_clock_enable <= 1'b0;
      ext_convert_mode <= 1'b0;
      conv_done_flag <= 1'b0;
      high_read_pending <= 1'b0;
      result <= aec_pkg::RESULT_RESET;
      state <= aec_pkg::AEC_IDLE;
      cnt <= 10'h000;
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      irq_o <= 1'b0;
      conv_active_o <= 1'b0;
      conv_power_o <= 1'b0;
    end else begin
      conv_irq_enable <= next_conv_irq_enable;
      continuous_conv_select <= next_continuous_conv_select;
      channel_select <= next_channel_select;
      async_clock_enable <= next_async_clock_enable;
      ext_convert_mode <= next_ext_convert_mode;
      conv_done_flag <= next_conv_done_flag;
      high_read_pending <= next_high_read_pending;
      result <= next_result;
      state <= next_state;
      cnt <= next_cnt;
      ack_o <= next_ack;
      dat_o <= next_dat;
      irq_o <= next_irq;
      conv_active_o <= next_state == aec_pkg::AEC_CONV;
      conv_power_o <= next_state == aec_pkg::AEC_CONV;
    end
  end

  // flag rises exactly one cycle after a conversion end
  AST_DONE_SET: assert property (@(posedge clk_i)
    disable iff (rst_i) conv_end |=> conv_done_flag)
    else $error("done flag missed");
  // interrupt rises together with the flag when enabled
  AST_IRQ_SET: assert property (@(posedge clk_i)
    disable iff (rst_i) conv_end && conv_irq_enable
    |=> irq_o && conv_done_flag)
    else $error("irq missed");
  // single mode powers down after its conversion
  AST_SINGLE_OFF: assert property (@(posedge clk_i)
    disable iff (rst_i) conv_end && !continuous_conv_select && !wr_sc
    |=> state == aec_pkg::AEC_IDLE)
    else $error("single did not stop");
  // stop without the async clock aborts at once
  AST_STOP_ABORT: assert property (@(posedge clk_i)
    disable iff (rst_i) stop_q && !async_clock_enable
    && state == aec_pkg::AEC_CONV |=> state == aec_pkg::AEC_IDLE)
    else $error("no abort");
  // without the async clock only a control write starts
  AST_NO_SELF_RESTART: assert property (@(posedge clk_i)
    disable iff (rst_i) state == aec_pkg::AEC_IDLE && !wr_sc
    && !async_clock_enable |=> state == aec_pkg::AEC_IDLE)
    else $error("self restart");
  // result changes only at a conversion end
  AST_RESULT_HOLD: assert property (@(posedge clk_i)
    disable iff (rst_i) !conv_end |=> $stable(result))
    else $error("result changed");
  // protected break keeps the flag
  AST_BREAK_PROTECT: assert property (@(posedge clk_i)
    disable iff (rst_i) brk_q && !bce_q && conv_done_flag && !conv_end
    |=> conv_done_flag)
    else $error("flag cleared in break");
  // control write clears the flag when clears are allowed
  AST_WRITE_CLEAR: assert property (@(posedge clk_i)
    disable iff (rst_i) wr_sc && clr_ok && !conv_end
    |=> !conv_done_flag ##1 !ack_o)
    else $error("write did not clear");
  // continuous mode goes straight into the next conversion
  AST_CONT_RUN: assert property (@(posedge clk_i)
    disable iff (rst_i) conv_end && continuous_conv_select && !stop_q
    && !wr_sc |=> state == aec_pkg::AEC_CONV && cnt == 10'h000)
    else $error("continuous stopped");
  // low result read drops the request
  AST_IRQ_DROP: assert property (@(posedge clk_i)
    disable iff (rst_i) rd_lo && clr_ok && !conv_end |=> !irq_o)
    else $error("irq kept");
  // low read clears the flag when clears are allowed and no conversion ends
  AST_LOW_READ_CLEAR: assert property (@(posedge clk_i)
    disable iff (rst_i) rd_lo && clr_ok && !conv_end |=> !conv_done_flag)
    else $error("read did not clear");
  // wait mode never ends a running conversion early
  AST_WAIT_RUN: assert property (@(posedge clk_i)
    disable iff (rst_i) wait_q && state == aec_pkg::AEC_CONV && !conv_end
    && !wr_sc && !stop_q |=> state == aec_pkg::AEC_CONV)
    else $error("wait stopped a conversion");
  // ext mode in stop stays powered down until the trigger
  AST_EXT_HOLD: assert property (@(posedge clk_i)
    disable iff (rst_i) state == aec_pkg::AEC_IDLE && ext_hold && !hw_trig
    |=> state == aec_pkg::AEC_IDLE)
    else $error("ext mode started without trigger");
  // an armed high read survives a protected break
  AST_TWO_STEP: assert property (@(posedge clk_i)
    disable iff (rst_i) high_read_pending && !clr_ok |=> high_read_pending)
    else $error("two-step arm lost");
  // an all-ones channel write leaves the converter off
  AST_CH_OFF_IDLE: assert property (@(posedge clk_i)
    disable iff (rst_i) wr_sc
    && dat_i[aec_pkg::CH_LSB +: aec_pkg::CH_W] == aec_pkg::CH_OFF
    |=> state == aec_pkg::AEC_IDLE)
    else $error("channel off still converting");
endmodule // aec_ctrl

/* File: dv/aec_ctrl_tb.sv */
// Purpose: self-checking bench for the converter event and power control
// Assumes: one clock at 125 MHz, wishbone classic master driven here
// Notes: sar data is random from a fixed xorshift seed, held per conversion
`timescale 1ns/1ns
module aec_ctrl_tb;
  // short names for the register offsets
  localparam logic [3:0] A_SC = aec_pkg::OFF_STATUS_CONTROL;
  localparam logic [3:0] A_HI = aec_pkg::OFF_RESULT_HIGH;
  localparam logic [3:0] A_LO = aec_pkg::OFF_RESULT_LOW;
  localparam logic [3:0] A_MD = aec_pkg::OFF_MODE;
  // design inputs, all valued at time zero
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic wait_mode_i = 1'b0;
  logic stop_mode_i = 1'b0;
  logic break_state_i = 1'b0;
  logic break_clear_enable_i = 1'b0;
  logic [9:0] sar_data_i = 10'h0;
  // design outputs
  logic [31:0] dat_o;
  logic ack_o;
  logic conv_active_o;
  logic conv_power_o;
  logic irq_o;
  // bench state
  int miscompares = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h29b9;
  logic [31:0] rd;
  logic [9:0] res;
  logic [9:0] last;
  logic [4:0] ch;
  logic seen;

  // free-running clock, 8 ns period
  always #4 clk_i = ~clk_i;

  aec_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .wait_mode_i(wait_mode_i), .stop_mode_i(stop_mode_i),
    .break_state_i(break_state_i),
    .break_clear_enable_i(break_clear_enable_i), .sar_data_i(sar_data_i),
    .conv_active_o(conv_active_o), .conv_power_o(conv_power_o),
    .irq_o(irq_o));

  // compare and count
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // xorshift step
  function logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // status_control_reg image from its fields
  function logic [31:0] ctl(input logic ie, input logic ct,
    input logic [4:0] c);
    return (32'(ie) << aec_pkg::BIT_IRQ_EN) | (32'(ct) << aec_pkg::BIT_CONT)
      | (32'(c) << aec_pkg::CH_LSB);
  endfunction

  // one classic cycle; holds until ack is sampled, then releases
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    if (n >= 50) miscompares++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  // wait for the interrupt under a bound longer than a conversion
  task wait_irq;
    int n;
    n = 0;
    seen = 1'b0;
    while (!seen && n < 1100) begin
      @(posedge clk_i);
      n++;
      if (irq_o === 1'b1) seen = 1'b1;
    end
  endtask

  // new random analog result
  task new_sample;
    seed = xs(seed);
    sar_data_i <= seed[9:0];
    res = seed[9:0];
  endtask

  // read high then low and compare with the expected result
  task read_result(input logic [9:0] e);
    wb(1'b0, A_HI, 32'h0);
    check(rd, {30'h0, e[9:8]});
    wb(1'b0, A_LO, 32'h0);
    check(rd, {24'h0, e[7:0]});
  endtask

  // watchdog, far beyond the expected run length
  initial begin
    #(8 * 60000);
    miscompares++;
    print_verdict;
  end

  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, A_SC, 32'h0);
    check(rd, 32'(aec_pkg::CH_RESET));
    check(irq_o, 1'b0);
    wb(1'b1, 4'h2, 32'hff);
    wb(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    check(conv_active_o, 1'b0);
    $display("test reset and map done");
    // single conversions with interrupt, random channel
    for (int i = 0; i < 2; i++) begin
      new_sample;
      seed = xs(seed);
      ch = (seed[4:0] == 5'h1f) ? 5'h03 : seed[4:0];
      wb(1'b1, A_SC, ctl(1'b1, 1'b0, ch));
      wait_irq;
      check(seen, 1'b1);
      repeat (2) @(posedge clk_i);
      check(conv_active_o, 1'b0);
      check(conv_power_o, 1'b0);
      wb(1'b0, A_SC, 32'h0);
      check(rd, ctl(1'b1, 1'b0, ch) | 32'h80);
      read_result(res);
      check(irq_o, 1'b0);
      wb(1'b0, A_SC, 32'h0);
      check(rd[7], 1'b0);
    end
    $display("test single done");
    // interrupt disabled, then the channel-off write
    new_sample;
    wb(1'b1, A_SC, ctl(1'b0, 1'b0, 5'h04));
    repeat (1010) @(posedge clk_i);
    check(irq_o, 1'b0);
    wb(1'b0, A_SC, 32'h0);
    check(rd, ctl(1'b0, 1'b0, 5'h04) | 32'h80);
    wb(1'b1, A_SC, ctl(1'b1, 1'b0, aec_pkg::CH_OFF));
    wb(1'b0, A_SC, 32'h0);
    check(rd[7], 1'b0);
    check(conv_active_o, 1'b0);
    $display("test flag and channel off done");
    // continuous conversions while in wait mode
    wait_mode_i <= 1'b1;
    new_sample;
    wb(1'b1, A_SC, ctl(1'b1, 1'b1, 5'h05));
    for (int i = 0; i < 2; i++) begin
      wait_irq;
      check(seen, 1'b1);
      read_result(res);
      last = res;
      new_sample;
    end
    wb(1'b1, A_SC, ctl(1'b0, 1'b0, aec_pkg::CH_OFF));
    wait_mode_i <= 1'b0;
    $display("test continuous in wait done");
    // stop without the async clock aborts and does not restart
    wb(1'b1, A_MD, 32'h0);
    sar_data_i <= ~last;
    wb(1'b1, A_SC, ctl(1'b1, 1'b0, 5'h06));
    repeat (100) @(posedge clk_i);
    stop_mode_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check(conv_active_o, 1'b0);
    check(conv_power_o, 1'b0);
    stop_mode_i <= 1'b0;
    repeat (1100) @(posedge clk_i);
    check(irq_o, 1'b0);
    check(conv_active_o, 1'b0);
    read_result(last);
    $display("test stop abort done");
    // async clock keeps converting in stop; ext mode waits for trigger
    wb(1'b1, A_MD, 32'h1 << aec_pkg::BIT_ASYNC_CLK);
    new_sample;
    wb(1'b1, A_SC, ctl(1'b1, 1'b0, 5'h07));
    stop_mode_i <= 1'b1;
    wait_irq;
    check(seen, 1'b1);
    read_result(res);
    wb(1'b1, A_MD, 32'h3);
    wb(1'b1, A_SC, ctl(1'b1, 1'b0, 5'h08));
    repeat (1100) @(posedge clk_i);
    check(irq_o, 1'b0);
    check(conv_active_o, 1'b0);
    stop_mode_i <= 1'b0;
    wb(1'b1, A_MD, 32'h0);
    $display("test stop async done");
    // break protects the flag unless clearing is enabled
    new_sample;
    wb(1'b1, A_SC, ctl(1'b0, 1'b0, 5'h09));
    repeat (1010) @(posedge clk_i);
    break_state_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(1'b0, A_LO, 32'h0);
    wb(1'b0, A_SC, 32'h0);
    check(rd[7], 1'b1);
    break_clear_enable_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(1'b0, A_LO, 32'h0);
    break_state_i <= 1'b0;
    break_clear_enable_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, A_SC, 32'h0);
    check(rd[7], 1'b0);
    // two-step clear: first step before the break, second after
    new_sample;
    wb(1'b1, A_SC, ctl(1'b0, 1'b0, 5'h0a));
    repeat (1010) @(posedge clk_i);
    wb(1'b0, A_HI, 32'h0);
    break_state_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(1'b0, A_SC, 32'h0);
    check(rd[7], 1'b1);
    break_state_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, A_LO, 32'h0);
    check(rd, {24'h0, res[7:0]});
    wb(1'b0, A_SC, 32'h0);
    check(rd[7], 1'b0);
    $display("test break done");
    print_verdict;
  end
endmodule // aec_ctrl_tb
